// *** design/sbwd_top.sv ***
/*
 Secondary bus window decode: window registers, routing of host and
 secondary master transactions, and secondary bus status flags.
 Assumes arst_n is the power-good reset, bus_rst_n a synchronous bus
 reset, and all request and event inputs synchronous to sys_clk.
*/
// Design decision made here: register access over APB.
// Operation
// (RL1) IO hit needs upper sixteen bits zero; code ignores them for host legacy video IO hits
// (RL2) IO limit 15:12, base 7:4
// (RL3) Memory window: base zeros, limit ones
// (RL4) Memory limit 31:20, base 15:4
// (RL5) Prefetchable window decoded the same way
// (RL6) Prefetchable limit 31:20, low bits ones
// (RL7) Host hits inside windows go secondary
// (RL8) Secondary hits inside windows not claimed
// (RL9) Host misses unclaimed elsewhere go LPC
// (RL10) Secondary misses claimed, passed to host
// (RL11) Empty windows: all secondary traffic upstream; code leaves configuration cycles unclaimed
// (RL12) Video and alias enables modify decode
// (RL13) Video memory and IO ranges go secondary
// (RL14) Alias enable keeps first 256 per 1K
// (RL15) Detected parity flag on three errors
// (RL16) System error input sets its flag
// (RL17) Master and target aborts set flags
// (RL18) Host error response signals target abort
// (RL19) Device select timing reads as medium
// (RL20) Master parity flag gated by response enable
// (RL21) Master parity flag rising raises NMI
// (RL22) Four flags survive bus reset
// (RL23) Window register reset values
// (RL24) Decode uses live register contents
`timescale 1ns/100ps
`include "sbwd_map.svh"
module sbwd_top
    import sbwd_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic bus_rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`SBWD_APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire sbwd_host_req_t host_req,
    output logic host_to_pci,
    output logic host_to_lpc,
    input wire sbwd_sec_req_t sec_req,
    output logic sec_claim,
    input wire sbwd_sec_evt_t sec_evt,
    input wire logic secondary_system_error_n,
    input wire logic secondary_parity_error_n,
    output logic signal_target_abort,
    output logic nmi_req
);
    localparam int NFLAG = 6;
    localparam int F_DETPAR = 0;
    localparam int F_SYSERR = 1;
    localparam int F_MABORT = 2;
    localparam int F_TABORT = 3;
    localparam int F_SABORT = 4;
    localparam int F_MPAR = 5;
    localparam int FLAG_POS [NFLAG] = '{`SBWD_DETPAR_BIT, `SBWD_SYSERR_BIT,
        `SBWD_MABORT_BIT, `SBWD_TABORT_BIT, `SBWD_SABORT_BIT, `SBWD_MPAR_BIT};
    localparam bit [NFLAG-1:0] CLR_ON_BUS = 6'h21;
    localparam logic [31:0] IO_RST = `SBWD_IO_WIN_RST;
    localparam logic [31:0] MEM_RST = `SBWD_MEM_WIN_RST;

    logic [3:0] io_window_limit;
    logic [3:0] io_window_base;
    logic [11:0] np_mem_window_limit;
    logic [11:0] np_mem_window_base;
    logic [11:0] pf_mem_window_limit;
    logic [11:0] pf_mem_window_base;
    logic legacy_video_decode_enable;
    logic legacy_io_alias_enable;
    logic parity_response_enable;
    logic [NFLAG-1:0] flag_ff;
    logic [NFLAG-1:0] flag_set;
    logic [NFLAG-1:0] flag_w1c;
    logic [31:0] prdata_ff;
    logic pslverr_ff;
    logic sent_abort_ff;
    logic mst_par_prev_ff;
    logic nmi_ff;
    logic wr_en;
    logic rd_setup;
    logic sel_io, sel_np, sel_pf, sel_ctrl;
    logic mapped;
    logic [31:0] io_reg_val;
    logic [31:0] np_reg_val;
    logic [31:0] pf_reg_val;
    logic [31:0] ctrl_reg_val;
    logic [31:0] rd_mux;
    logic [31:0] src_addr [2];
    logic io_match [2], np_match [2], pf_match [2];
    logic win_hit [2];
    logic host_is_io;
    logic vga_mem_hit, vga_io_hit;
    logic host_hit;
    logic sent_abort_evt;

    // APB decode
    assign sel_io = (paddr == `SBWD_IO_WIN_OFF);
    assign sel_np = (paddr == `SBWD_NP_WIN_OFF);
    assign sel_pf = (paddr == `SBWD_PF_WIN_OFF);
    assign sel_ctrl = (paddr == `SBWD_CTRL_OFF);
    assign mapped = sel_io | sel_np | sel_pf | sel_ctrl;
    assign wr_en = psel & penable & pwrite & mapped;
    assign rd_setup = psel & ~penable;
    assign pready = psel & penable;
    assign prdata = prdata_ff;
    assign pslverr = pslverr_ff & psel & penable;

    always_comb begin
        io_reg_val = 32'h00000000;
        for (int i = 0; i < NFLAG; i++) begin
            io_reg_val[FLAG_POS[i]] = flag_ff[i];
        end
        io_reg_val[26:25] = `SBWD_DEVSEL_MEDIUM; // [RL19]
        io_reg_val[`SBWD_IO_LIM_HI -: 4] = io_window_limit; // [RL2]
        io_reg_val[`SBWD_IO_BASE_HI -: 4] = io_window_base;
    end

    assign np_reg_val = {np_mem_window_limit, 4'h0,
                         np_mem_window_base, 4'h0}; // [RL4]
    assign pf_reg_val = {pf_mem_window_limit, 4'h0,
                         pf_mem_window_base, 4'h0}; // [RL6]
    assign ctrl_reg_val = {29'h00000000, parity_response_enable,
                           legacy_io_alias_enable,
                           legacy_video_decode_enable};

    always_comb begin
        rd_mux = 32'h00000000;
        if (sel_io) begin
            rd_mux = io_reg_val;
        end else if (sel_np) begin
            rd_mux = np_reg_val;
        end else if (sel_pf) begin
            rd_mux = pf_reg_val;
        end else if (sel_ctrl) begin
            rd_mux = ctrl_reg_val;
        end
    end

    // Read data captured in the setup cycle, stable through access
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata_ff <= 32'h00000000;
            pslverr_ff <= 1'b0;
        end else if (rd_setup) begin
            prdata_ff <= pwrite ? 32'h00000000 : rd_mux;
            pslverr_ff <= ~mapped;
        end
    end

    // Window and control registers; the bus reset also restores them
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            io_window_limit <= IO_RST[15:12]; // [RL23]
            io_window_base <= IO_RST[7:4];
            np_mem_window_limit <= MEM_RST[31:20];
            np_mem_window_base <= MEM_RST[15:4];
            pf_mem_window_limit <= MEM_RST[31:20];
            pf_mem_window_base <= MEM_RST[15:4];
        end else if (!bus_rst_n) begin
            io_window_limit <= IO_RST[15:12]; // [RL23]
            io_window_base <= IO_RST[7:4];
            np_mem_window_limit <= MEM_RST[31:20];
            np_mem_window_base <= MEM_RST[15:4];
            pf_mem_window_limit <= MEM_RST[31:20];
            pf_mem_window_base <= MEM_RST[15:4];
        end else if (wr_en) begin
            if (sel_io) begin
                io_window_limit <= pwdata[15:12]; // [RL2]
                io_window_base <= pwdata[7:4];
            end
            if (sel_np) begin
                np_mem_window_limit <= pwdata[31:20]; // [RL4]
                np_mem_window_base <= pwdata[15:4];
            end
            if (sel_pf) begin
                pf_mem_window_limit <= pwdata[31:20]; // [RL5]
                pf_mem_window_base <= pwdata[15:4];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            legacy_video_decode_enable <= 1'b0;
            legacy_io_alias_enable <= 1'b0;
            parity_response_enable <= 1'b0;
        end else if (!bus_rst_n) begin
            legacy_video_decode_enable <= 1'b0;
            legacy_io_alias_enable <= 1'b0;
            parity_response_enable <= 1'b0;
        end else if (wr_en && sel_ctrl) begin
            legacy_video_decode_enable <= pwdata[`SBWD_CTRL_VGA_BIT];
            legacy_io_alias_enable <= pwdata[`SBWD_CTRL_ISA_BIT];
            parity_response_enable <= pwdata[`SBWD_CTRL_PER_BIT];
        end
    end

    // Window compare, index 0 host, index 1 secondary master
    assign src_addr[0] = host_req.addr;
    assign src_addr[1] = sec_req.addr;
    assign host_is_io = host_req.is_io;

    generate
        for (genvar g = 0; g < 2; g++) begin : g_src
            logic is_io;
            logic alias_ok;
            assign is_io = (g == 0) ? host_is_io :
                           (sec_req.kind == SBWD_KIND_IO);
            sbwd_window_match #(.ADDR_W(16), .FIELD_W(4)) u_io (
                .addr(src_addr[g][15:0]),
                .base(io_window_base),
                .limit(io_window_limit),
                .hit(io_match[g])
            );
            sbwd_window_match #(.ADDR_W(32), .FIELD_W(12)) u_np (
                .addr(src_addr[g]),
                .base(np_mem_window_base),
                .limit(np_mem_window_limit),
                .hit(np_match[g])
            ); // [RL3]
            sbwd_window_match #(.ADDR_W(32), .FIELD_W(12)) u_pf (
                .addr(src_addr[g]),
                .base(pf_mem_window_base),
                .limit(pf_mem_window_limit),
                .hit(pf_match[g])
            ); // [RL5] [RL6]
            // Alias mode passes only the first 256 bytes of each 1K
            assign alias_ok = !legacy_io_alias_enable ||
                              (src_addr[g][9:8] == 2'h0); // [RL14] [RL12]
            // Combinational against live registers [RL24]
            assign win_hit[g] = is_io ?
                (src_addr[g][31:16] == 16'h0000) && io_match[g] &&
                alias_ok : // [RL1]
                (np_match[g] || pf_match[g]);
        end
    endgenerate

    // Legacy video ranges widen the host decode only
    assign vga_mem_hit = legacy_video_decode_enable && !host_is_io &&
        (host_req.addr >= `SBWD_VGA_MEM_LO) &&
        (host_req.addr <= `SBWD_VGA_MEM_HI); // [RL13] [RL12]
    assign vga_io_hit = legacy_video_decode_enable && host_is_io &&
        (((host_req.addr[9:0] >= `SBWD_VGA_IO1_LO) &&
          (host_req.addr[9:0] <= `SBWD_VGA_IO1_HI)) ||
         ((host_req.addr[9:0] >= `SBWD_VGA_IO2_LO) &&
          (host_req.addr[9:0] <= `SBWD_VGA_IO2_HI))); // [RL13]
    assign host_hit = win_hit[0] || vga_mem_hit || vga_io_hit;

    assign host_to_pci = host_req.valid && host_hit; // [RL7]
    assign host_to_lpc = host_req.valid && !host_hit &&
                         !host_req.other_claim; // [RL9]
    // Configuration cycles are never passed upstream
    assign sec_claim = sec_req.valid && !win_hit[1] &&
        (sec_req.kind != SBWD_KIND_CFG); // [RL8] [RL10] [RL11]

    // Status flag events
    assign sent_abort_evt = sec_evt.host_rsp_valid &&
        sec_evt.host_rsp_error && !sec_evt.nonexistent_address_error; // [RL18]
    assign flag_set[F_DETPAR] = sec_evt.addr_par_err_tgt ||
        sec_evt.data_par_err_tgt_wr ||
        sec_evt.data_par_err_mst_rd; // [RL15]
    assign flag_set[F_SYSERR] = !secondary_system_error_n; // [RL16]
    assign flag_set[F_MABORT] = sec_evt.master_abort_rcvd; // [RL17]
    assign flag_set[F_TABORT] = sec_evt.target_abort_rcvd; // [RL17]
    assign flag_set[F_SABORT] = sent_abort_evt;
    assign flag_set[F_MPAR] = parity_response_enable &&
        (sec_evt.data_par_err_mst_rd ||
         (!secondary_parity_error_n && sec_evt.mst_write_phase)); // [RL20]

    generate
        for (genvar f = 0; f < NFLAG; f++) begin : g_flag
            assign flag_w1c[f] = wr_en && sel_io && pwdata[FLAG_POS[f]];
            sbwd_w1c_flag #(.CLR_ON_BUS_RST(CLR_ON_BUS[f])) u_flag (
                .sys_clk(sys_clk),
                .arst_n(arst_n),
                .bus_rst_n(bus_rst_n),
                .set(flag_set[f]),
                .w1c(flag_w1c[f]),
                .flag_ff(flag_ff[f])
            ); // [RL22]
        end
    endgenerate

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sent_abort_ff <= 1'b0;
        end else begin
            sent_abort_ff <= sent_abort_evt; // [RL18]
        end
    end
    assign signal_target_abort = sent_abort_ff;

    // One pulse per rising edge of the master parity flag
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            mst_par_prev_ff <= 1'b0;
            nmi_ff <= 1'b0;
        end else begin
            mst_par_prev_ff <= flag_ff[F_MPAR];
            nmi_ff <= flag_ff[F_MPAR] && !mst_par_prev_ff; // [RL21]
        end
    end
    assign nmi_req = nmi_ff;

    AST_IO_UPPER_ZERO: assert property (@(posedge sys_clk) // [RL1]
        disable iff (!arst_n)
        (host_req.valid && host_req.is_io && host_req.addr[31:16] != 0 &&
         !legacy_video_decode_enable) |-> !host_to_pci)
        else $error("io above 64K routed to secondary bus");

    AST_ROUTE_EXCL: assert property (@(posedge sys_clk) // [RL9]
        disable iff (!arst_n)
        !(host_to_pci && host_to_lpc))
        else $error("host request routed to two buses");

    AST_CFG_NOT_CLAIMED: assert property (@(posedge sys_clk) // [RL11]
        disable iff (!arst_n)
        (sec_req.kind == SBWD_KIND_CFG) |-> !sec_claim)
        else $error("configuration cycle claimed");

    AST_ALIAS_FILTER: assert property (@(posedge sys_clk) // [RL14]
        disable iff (!arst_n)
        (legacy_io_alias_enable && sec_req.valid &&
         sec_req.kind == SBWD_KIND_IO && sec_req.addr[9:8] != 0)
        |-> sec_claim)
        else $error("aliased io address not passed upstream");

    AST_SENT_ABORT_PULSE: assert property (@(posedge sys_clk) // [RL18]
        disable iff (!arst_n)
        sent_abort_evt |=> signal_target_abort && flag_ff[F_SABORT])
        else $error("target abort not signaled or not flagged");

    AST_NMI_ON_MASTER_PARITY: assert property (@(posedge sys_clk) // [RL21]
        disable iff (!arst_n)
        $rose(flag_ff[F_MPAR]) |=> nmi_req ##1 !nmi_req)
        else $error("nmi not pulsed on master parity flag");

    AST_DEVSEL_READ: assert property (@(posedge sys_clk) // [RL19]
        disable iff (!arst_n)
        (rd_setup && !pwrite && sel_io) |=> prdata[26:25] == 2'h1)
        else $error("device select timing not medium");

    AST_KEEP_ON_BUS_RST: assert property (@(posedge sys_clk) // [RL22]
        disable iff (!arst_n)
        (!bus_rst_n && !wr_en && flag_ff[F_SYSERR] && flag_ff[F_MABORT])
        |=> flag_ff[F_SYSERR] && flag_ff[F_MABORT])
        else $error("sticky flag lost on bus reset");

    AST_PARITY_GATE: assert property (@(posedge sys_clk) // [RL20]
        disable iff (!arst_n)
        (!parity_response_enable && !flag_ff[F_MPAR]) |=> !flag_ff[F_MPAR])
        else $error("master parity flag set while disabled");

    AST_WIN_RESET: assert property (@(posedge sys_clk) // [RL23]
        disable iff (!arst_n)
        !bus_rst_n |=> np_reg_val == MEM_RST && io_window_base == 4'hF)
        else $error("window registers not at reset value");
endmodule

// *** design/sbwd_map.svh ***
/*
 Register offsets, field positions, reset values and decode constants
 for the secondary bus window decode block.
 Assumes a 32-bit APB slave with byte addresses on an 8-bit paddr.
*/
`ifndef SBWD_MAP_SVH
`define SBWD_MAP_SVH

`define SBWD_APB_AW 8
`define SBWD_IO_WIN_OFF 8'h1C
`define SBWD_NP_WIN_OFF 8'h20
`define SBWD_PF_WIN_OFF 8'h24
`define SBWD_CTRL_OFF 8'h28

`define SBWD_IO_WIN_RST 32'h020000F0
`define SBWD_MEM_WIN_RST 32'h0000FFF0

`define SBWD_DETPAR_BIT 31
`define SBWD_SYSERR_BIT 30
`define SBWD_MABORT_BIT 29
`define SBWD_TABORT_BIT 28
`define SBWD_SABORT_BIT 27
`define SBWD_MPAR_BIT 24
`define SBWD_DEVSEL_MEDIUM 2'h1

`define SBWD_IO_LIM_HI 15
`define SBWD_IO_BASE_HI 7
`define SBWD_MEM_LIM_HI 31
`define SBWD_MEM_BASE_HI 15

`define SBWD_CTRL_VGA_BIT 0
`define SBWD_CTRL_ISA_BIT 1
`define SBWD_CTRL_PER_BIT 2

`define SBWD_VGA_MEM_LO 32'h000A0000
`define SBWD_VGA_MEM_HI 32'h000BFFFF
`define SBWD_VGA_IO1_LO 10'h3B0
`define SBWD_VGA_IO1_HI 10'h3BB
`define SBWD_VGA_IO2_LO 10'h3C0
`define SBWD_VGA_IO2_HI 10'h3DF

`endif

// *** design/sbwd_pkg.sv ***
/*
 Types shared by the secondary bus window decode block.
 Assumes the constants header is included where offsets are needed.
*/
package sbwd_pkg;

    typedef enum logic [1:0] {
        SBWD_KIND_MEM = 2'b00,
        SBWD_KIND_IO = 2'b01,
        SBWD_KIND_CFG = 2'b10
    } sbwd_kind_t;

    typedef struct packed {
        logic valid;
        logic is_io;
        logic other_claim;
        logic [31:0] addr;
    } sbwd_host_req_t;

    typedef struct packed {
        logic valid;
        sbwd_kind_t kind;
        logic [31:0] addr;
    } sbwd_sec_req_t;

    typedef struct packed {
        logic addr_par_err_tgt;
        logic data_par_err_tgt_wr;
        logic data_par_err_mst_rd;
        logic mst_write_phase;
        logic master_abort_rcvd;
        logic target_abort_rcvd;
        logic host_rsp_valid;
        logic host_rsp_error;
        logic nonexistent_address_error;
    } sbwd_sec_evt_t;

endpackage

// *** design/sbwd_window_match.sv ***
/*
 One address window comparator: base and limit give the upper address
 bits, the lower bits extend with zeros and ones.
 Assumes base, limit and address are stable in the same cycle.
*/
`timescale 1ns/100ps
module sbwd_window_match #(
    parameter int ADDR_W = 32,
    parameter int FIELD_W = 12
) (
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [FIELD_W-1:0] base,
    input wire logic [FIELD_W-1:0] limit,
    output logic hit
);
    localparam int LOW_W = ADDR_W - FIELD_W;

    // Base above limit gives an empty window by construction
    assign hit = (addr >= {base, {LOW_W{1'b0}}}) &&
                 (addr <= {limit, {LOW_W{1'b1}}});
endmodule

// *** design/sbwd_w1c_flag.sv ***
/*
 Sticky status flag set by hardware, cleared by a write of one, and
 optionally cleared by the secondary bus reset.
 Assumes set, w1c and bus_rst_n are synchronous to sys_clk.
*/
`timescale 1ns/100ps
module sbwd_w1c_flag #(
    parameter bit CLR_ON_BUS_RST = 1'b1
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic bus_rst_n,
    input wire logic set,
    input wire logic w1c,
    output logic flag_ff
);
    logic nxt_flag;

    // Set beats a clear in the same cycle
    always_comb begin
        nxt_flag = flag_ff;
        if (w1c) begin
            nxt_flag = 1'b0;
        end
        if (!bus_rst_n && CLR_ON_BUS_RST) begin
            nxt_flag = 1'b0;
        end
        if (set) begin
            nxt_flag = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            flag_ff <= 1'b0;
        end else begin
            flag_ff <= nxt_flag;
        end
    end

    AST_SET_WINS: assert property (@(posedge sys_clk) disable iff (!arst_n)
        set |=> flag_ff) // [RL15]
        else $error("flag lost a set event");
endmodule

// *** tb/sbwd_far_model.sv ***
/*
 Far side model: host link requests, secondary master requests and
 secondary bus status events, all driven through tasks.
 Assumes tasks are called right after a rising edge of sys_clk.
*/
`timescale 1ns/100ps
module sbwd_far_model
    import sbwd_pkg::*;
(
    input wire logic sys_clk,
    output sbwd_host_req_t host_req,
    output sbwd_sec_req_t sec_req,
    output sbwd_sec_evt_t sec_evt,
    output logic secondary_system_error_n,
    output logic secondary_parity_error_n
);
    initial begin
        host_req = '0;
        sec_req = '0;
        sec_evt = '0;
        secondary_system_error_n = 1'b1;
        secondary_parity_error_n = 1'b1;
    end

    // Both sources present one address so one probe covers both paths
    task automatic req(input logic io, input logic oc,
                       input logic [31:0] a, input sbwd_kind_t k);
        host_req <= '{1'b1, io, oc, a};
        sec_req <= '{1'b1, k, a};
    endtask

    // Released address shows the inverse, never a stale match
    task automatic rel();
        host_req <= '{1'b0, 1'b0, 1'b0, ~host_req.addr};
        sec_req <= '{1'b0, SBWD_KIND_MEM, ~sec_req.addr};
    endtask

    task automatic pulse(input sbwd_sec_evt_t e, input logic se,
                         input logic pe);
        @(posedge sys_clk);
        sec_evt <= e;
        secondary_system_error_n <= ~se;
        secondary_parity_error_n <= ~pe;
        @(posedge sys_clk);
        sec_evt <= '0;
        secondary_system_error_n <= 1'b1;
        secondary_parity_error_n <= 1'b1;
    endtask
endmodule

// *** tb/sbwd_top_tb.sv ***
/*
 Self-checking bench for the window decode block: APB register
 access, address decode and status flags.
 Assumes zero wait state APB and combinational decode outputs.
*/
`timescale 1ns/100ps
module sbwd_top_tb
    import sbwd_pkg::*;
();
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic bus_rst_n = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, host_to_pci, host_to_lpc, sec_claim;
    logic signal_target_abort, nmi_req;
    sbwd_host_req_t host_req;
    sbwd_sec_req_t sec_req;
    sbwd_sec_evt_t sec_evt;
    logic secondary_system_error_n, secondary_parity_error_n;
    int n_errors = 0;
    int compares = 0;

    sbwd_top u_sbwd_top (.sys_clk, .arst_n, .bus_rst_n, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .host_req, .host_to_pci, .host_to_lpc, .sec_req, .sec_claim,
        .sec_evt, .secondary_system_error_n, .secondary_parity_error_n,
        .signal_target_abort, .nmi_req);
    sbwd_far_model u_sbwd_far_model (.sys_clk, .host_req, .sec_req,
        .sec_evt, .secondary_system_error_n, .secondary_parity_error_n);

    initial begin
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic chb(input logic g, input logic e);
        chk({31'h0, g}, {31'h0, e});
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) begin
            @(posedge sys_clk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask

    // Unmapped places read zero and answer with an error
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, x);
        chb(e, !(a inside {8'h1C, 8'h20, 8'h24, 8'h28}));
    endtask

    // Entry: io, expected host_to_pci, expected sec_claim, address
    task automatic probe(input logic [34:0] t);
        @(posedge sys_clk);
        u_sbwd_far_model.req(t[34], 1'b0, t[31:0],
            t[34] ? SBWD_KIND_IO : SBWD_KIND_MEM);
        #1;
        chb(host_to_pci, t[33]);
        chb(host_to_lpc, !t[33]);
        chb(sec_claim, t[32]);
    endtask

    task automatic t_reset();
        rd(8'h1C, 32'h020000F0);
        rd(8'h20, 32'h0000FFF0);
        rd(8'h24, 32'h0000FFF0);
        rd(8'h28, 32'h0); 
        rd(8'h30, 32'h0);
        probe(35'h112345678);
        probe(35'h500002000);
        @(posedge sys_clk);
        u_sbwd_far_model.req(1'b0, 1'b1, 32'h5, SBWD_KIND_CFG);
        #1;
        chb(host_to_lpc, 1'b0);
        chb(sec_claim, 1'b0);
        $display("reset test done");
    endtask

    task automatic t_windows();
        logic [34:0] w [13];
        w = '{35'h10FFFFFFF, 35'h210000000, 35'h2100FFFFF, 35'h110100000,
              35'h1000FFFFF, 35'h200100000, 35'h200FFFFFF, 35'h101000000,
              35'h500001FFF, 35'h600002000, 35'h600003FFF, 35'h500004000,
              35'h500012000};
        wr(8'h20, 32'h10001000);
        wr(8'h24, 32'h00F00010);
        wr(8'h1C, 32'h00003020);
        rd(8'h20, 32'h10001000);
        rd(8'h24, 32'h00F00010);
        rd(8'h1C, 32'h02003020);
        foreach (w[i]) begin
            probe(w[i]);
        end
        $display("window test done");
    endtask

    task automatic t_legacy();
        logic [34:0] v [6];
        logic [34:0] s [4];
        v = '{35'h3000A0000, 35'h3000BFFFF, 35'h1000C0000,
              35'h7000003B0, 35'h5000003BC, 35'h7000007DF};
        s = '{35'h6000020FF, 35'h500002100, 35'h600002400, 35'h500003FFF};
        wr(8'h28, 32'h1);
        foreach (v[i]) probe(v[i]);
        wr(8'h28, 32'h2);
        rd(8'h28, 32'h2);
        foreach (s[i]) probe(s[i]);
        u_sbwd_far_model.rel();
        $display("legacy test done");
    endtask

    task automatic ev(input logic p, input logic [8:0] e,
                      input logic se, input logic pe, input logic xs,
                      input logic xn, input logic [31:0] m);
        wr(8'h28, {29'h0, p, 2'b00});
        u_sbwd_far_model.pulse(e, se, pe);
        #1;
        chb(signal_target_abort, xs);
        chb(nmi_req, 1'b0);
        @(posedge sys_clk);
        #1;
        chb(signal_target_abort, 1'b0);
        chb(nmi_req, xn);
        rd(8'h1C, 32'h02003020 | m);
        wr(8'h1C, 32'h00003020 | m);
        rd(8'h1C, 32'h02003020);
    endtask

    task automatic t_flags();
        ev(0, 9'h100, 0, 0, 0, 0, 32'h80000000);
        ev(0, 9'h080, 0, 0, 0, 0, 32'h80000000);
        ev(0, 9'h040, 0, 0, 0, 0, 32'h80000000);
        ev(0, 9'h000, 1, 0, 0, 0, 32'h40000000);
        ev(0, 9'h010, 0, 0, 0, 0, 32'h20000000);
        ev(0, 9'h008, 0, 0, 0, 0, 32'h10000000);
        ev(0, 9'h006, 0, 0, 1, 0, 32'h08000000);
        ev(0, 9'h007, 0, 0, 0, 0, 32'h0);
        ev(1, 9'h040, 0, 0, 0, 1, 32'h81000000);
        ev(1, 9'h020, 0, 1, 0, 1, 32'h01000000);
        $display("flag test done");
    endtask

    task automatic t_resets();
        wr(8'h28, 32'h4);
        u_sbwd_far_model.pulse(9'h15E, 1'b1, 1'b0);
        rd(8'h1C, 32'hFB003020);
        @(posedge sys_clk);
        bus_rst_n <= 1'b0;
        @(posedge sys_clk);
        bus_rst_n <= 1'b1;
        rd(8'h1C, 32'h7A0000F0);
        rd(8'h20, 32'h0000FFF0);
        rd(8'h28, 32'h0);
        @(posedge sys_clk);
        arst_n <= 1'b0;
        @(posedge sys_clk);
        arst_n <= 1'b1;
        rd(8'h1C, 32'h020000F0);
        $display("reset level test done");
    endtask

    task automatic summarize();
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Whole run needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        $display("ERROR %0t: timeout", $time);
        summarize();
    end

    initial begin
        repeat (6) @(posedge sys_clk);
        arst_n <= 1'b1;
        t_reset();
        t_windows();
        t_legacy();
        t_flags();
        t_resets();
        summarize();
    end
endmodule
